/* cshs_pkg.sv */
// Overview of operation
// - Hop uses shadow plus countdown, start countdown only
// - Countdown armed by soft sync or pin
// - Hard reset puts every channel asleep
// - Host may write sleep bits any time
// - Unsynced start: count 1, clear sleep
// - Ext 5 start plus sync arms countdown
// - Soft countdown at one clears sleep bits
// - Soft start latency is count plus six
// - Each channel selects any sync pin
// - Sampled pin arms countdown, one wakes channel
// - Pin start latency is count plus three
// - Start delayed by programmed count cycles
// - Zero tuning count: frequency applies at once
// - Hop committed by soft or pin sync
// - Ext 5 hop plus sync arms tuning countdown
// - Hop latency count plus seven or five
package cshs_pkg;
    localparam int NUM_CH   = 4;
    localparam int NUM_PIN  = 4;
    localparam int CNT_W    = 16;
    localparam int FREQ_W   = 32;
    localparam int EXT_AW   = 3;
    localparam int EXT_DW   = 8;
    localparam int CREG_AW  = 8;

    // External (microport) addresses
    localparam logic [EXT_AW-1:0] EXT_SLEEP     = 3'h3;
    localparam logic [EXT_AW-1:0] EXT_PIN_CTRL  = 3'h4;
    localparam logic [EXT_AW-1:0] EXT_SOFT_SYNC = 3'h5;
    // Field positions
    localparam int PIN_EN_LSB     = 0;
    localparam int START_PIN_BIT  = 4;
    localparam int HOP_PIN_BIT    = 5;
    localparam int SOFT_CH_LSB    = 0;
    localparam int SOFT_START_BIT = 4;
    localparam int SOFT_HOP_BIT   = 5;

    // Channel register offsets
    localparam logic [CREG_AW-1:0] CREG_START_DLY = 8'h83;
    localparam logic [CREG_AW-1:0] CREG_TUNE_DLY  = 8'h84;
    localparam logic [CREG_AW-1:0] CREG_FREQ      = 8'h85;
    localparam logic [CREG_AW-1:0] CREG_PIN_SEL   = 8'h86;

    // Reset values
    localparam logic [NUM_CH-1:0] SLEEP_RST     = 4'hF;
    localparam logic [CNT_W-1:0]  START_DLY_RST = 16'h0001;
    localparam logic [CNT_W-1:0]  TUNE_DLY_RST  = 16'h0000;

    // Fixed latencies beyond the count
    localparam int START_SOFT_EXTRA = 6;
    localparam int HOP_SOFT_EXTRA   = 7;
    localparam int START_PIN_EXTRA  = 3;
    localparam int HOP_PIN_EXTRA    = 5;
    localparam int RDY_LAG          = 1;
    localparam int SYNC_LAG         = 2;
    localparam int START_SOFT_PIPE  = START_SOFT_EXTRA + RDY_LAG;
    localparam int HOP_SOFT_PIPE    = HOP_SOFT_EXTRA + RDY_LAG;
    localparam int START_PIN_PIPE   = START_PIN_EXTRA - SYNC_LAG;
    localparam int HOP_PIN_PIPE     = HOP_PIN_EXTRA - SYNC_LAG;
endpackage

/* cshs_hold_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Arm and commit signals of one hold-off counter
interface cshs_hold_if #(parameter int W = 16);
    logic         soft_arm;
    logic         pin_arm;
    logic [W-1:0] load_val;
    logic         fire;
    modport ctl (output soft_arm, output pin_arm, output load_val, input fire);
    modport cnt (input soft_arm, input pin_arm, input load_val, output fire);
endinterface
`default_nettype wire

/* cshs_holdoff.sv */
`timescale 1ns/100ps
`default_nettype none
module cshs_holdoff #(
    parameter int SOFT_DLY = 7,
    parameter int PIN_DLY  = 1,
    parameter int W        = 16
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    cshs_hold_if.cnt  hs
);
    typedef struct packed {
        logic [SOFT_DLY-1:0] pipe_s;
        logic [PIN_DLY-1:0]  pipe_p;
        logic [W-1:0]        cnt;
        logic                busy;
    } cshs_hold_type;

    cshs_hold_type st_ff;
    cshs_hold_type nxt_st;
    logic          load;
    logic [W-1:0]  one;

    assign one  = W'(1);
    assign load = st_ff.pipe_s[SOFT_DLY-1] | st_ff.pipe_p[PIN_DLY-1];

    // Arm delay lines, countdown, commit strobe
    always_comb begin
        nxt_st = st_ff;
        // Oldest stage falls off the top of each delay line
        nxt_st.pipe_s = SOFT_DLY'({st_ff.pipe_s, hs.soft_arm});
        nxt_st.pipe_p = PIN_DLY'({st_ff.pipe_p, hs.pin_arm});
        hs.fire = 1'b0;
        if (load) begin
            nxt_st.cnt  = (hs.load_val == '0) ? one : hs.load_val;
            nxt_st.busy = hs.load_val > one;
            hs.fire     = hs.load_val <= one;
        end else if (st_ff.busy) begin
            nxt_st.cnt  = st_ff.cnt - one;
            nxt_st.busy = st_ff.cnt > W'(2);
            hs.fire     = st_ff.cnt == W'(2);
        end
    end

    // State register; reset clears counter, idle counter holds its value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '{pipe_s: '0, pipe_p: '0, cnt: '0, busy: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    localparam int SLEN = SOFT_DLY;
    localparam int PLEN = PIN_DLY;

    chk_count_step: assert property (@(posedge clk_sys) disable iff (rst)
        st_ff.busy && !load |=> st_ff.cnt == $past(st_ff.cnt) - one)
        else $error("hold-off counter did not step down");
    chk_stop_one: assert property (@(posedge clk_sys) disable iff (rst)
        hs.fire |=> st_ff.cnt == one && !st_ff.busy)
        else $error("counter not parked at one after commit");
    chk_idle_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !st_ff.busy && !load |=> $stable(st_ff.cnt) && !$past(hs.fire))
        else $error("idle counter moved or fired");
    chk_soft_arm: assert property (@(posedge clk_sys) disable iff (rst)
        hs.soft_arm |-> ##SLEN load)
        else $error("soft sync did not load counter on time");
    chk_pin_arm: assert property (@(posedge clk_sys) disable iff (rst)
        hs.pin_arm |-> ##PLEN load)
        else $error("pin sync did not load counter on time");
    cov_long_count: cover property (@(posedge clk_sys) disable iff (rst)
        st_ff.busy && st_ff.cnt == W'(2) ##1 !st_ff.busy);
endmodule
`default_nettype wire

/* cshs_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cshs_top (
    input  wire logic                                       clk_sys,
    input  wire logic                                       rst,
    input  wire logic [cshs_pkg::EXT_AW-1:0]                ext_addr,
    input  wire logic                                       ext_wr,
    input  wire logic                                       ext_rd,
    input  wire logic [cshs_pkg::EXT_DW-1:0]                ext_wdata,
    output logic      [cshs_pkg::EXT_DW-1:0]                ext_rdata,
    output logic                                            rdy,
    input  wire logic [1:0]                                 creg_ch,
    input  wire logic [cshs_pkg::CREG_AW-1:0]               creg_addr,
    input  wire logic                                       creg_wr,
    input  wire logic                                       creg_rd,
    input  wire logic [cshs_pkg::FREQ_W-1:0]                creg_wdata,
    output logic      [cshs_pkg::FREQ_W-1:0]                creg_rdata,
    input  wire logic [cshs_pkg::NUM_PIN-1:0]               sync_pin,
    output logic      [cshs_pkg::NUM_CH-1:0]                chan_sleep,
    output logic      [cshs_pkg::NUM_CH-1:0][cshs_pkg::FREQ_W-1:0] tuning_word
);
    localparam int NC = cshs_pkg::NUM_CH;
    localparam int NP = cshs_pkg::NUM_PIN;
    localparam int CW = cshs_pkg::CNT_W;
    localparam int FW = cshs_pkg::FREQ_W;

    typedef struct packed {
        logic [NC-1:0]          sleep;
        logic [NP-1:0]          pin_en;
        logic                   start_pin;
        logic                   hop_pin;
        logic [NC-1:0][CW-1:0]  start_dly;
        logic [NC-1:0][CW-1:0]  tune_dly;
        logic [NC-1:0][FW-1:0]  shadow;
        logic [NC-1:0][FW-1:0]  tuning;
        logic [NC-1:0][1:0]     pin_sel;
        logic [NC-1:0]          soft_start;
        logic [NC-1:0]          soft_hop;
        logic [NP-1:0]          sync1;
        logic [NP-1:0]          sync2;
        logic [NP-1:0]          sync3;
        logic [NP-1:0]          agreed;
        logic                   rdy;
        logic [cshs_pkg::EXT_DW-1:0] ext_rdata;
        logic [FW-1:0]          creg_rdata;
    } cshs_top_type;

    cshs_top_type st_ff;
    cshs_top_type nxt_st;
    logic [NP-1:0] pin_rise;
    logic [NC-1:0] start_fire;
    logic [NC-1:0] hop_fire;

    // Selected pin of a channel rose, if enabled
    function automatic logic pin_hit(input logic [1:0] sel, input logic [NP-1:0] rise,
                                     input logic [NP-1:0] en);
        pin_hit = rise[sel] & en[sel];
    endfunction

    // Second and third stages agree on a new high level
    assign pin_rise = st_ff.sync2 & st_ff.sync3 & ~st_ff.agreed;

    // One start and one hop hold-off counter per channel
    for (genvar i = 0; i < NC; i++) begin : g_ch
        cshs_hold_if #(.W(CW)) hs_start ();
        cshs_hold_if #(.W(CW)) hs_hop ();
        assign hs_start.soft_arm = st_ff.soft_start[i];
        assign hs_start.pin_arm  = st_ff.start_pin &
                                   pin_hit(st_ff.pin_sel[i], pin_rise, st_ff.pin_en);
        assign hs_start.load_val = st_ff.start_dly[i];
        assign start_fire[i]     = hs_start.fire;
        assign hs_hop.soft_arm   = st_ff.soft_hop[i];
        assign hs_hop.pin_arm    = st_ff.hop_pin &
                                   pin_hit(st_ff.pin_sel[i], pin_rise, st_ff.pin_en);
        assign hs_hop.load_val   = st_ff.tune_dly[i];
        assign hop_fire[i]       = hs_hop.fire;
        cshs_holdoff #(
            .SOFT_DLY (cshs_pkg::START_SOFT_PIPE),
            .PIN_DLY  (cshs_pkg::START_PIN_PIPE),
            .W        (CW)
        ) u_start (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .hs       (hs_start)
        );
        cshs_holdoff #(
            .SOFT_DLY (cshs_pkg::HOP_SOFT_PIPE),
            .PIN_DLY  (cshs_pkg::HOP_PIN_PIPE),
            .W        (CW)
        ) u_hop (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .hs       (hs_hop)
        );
    end

    // Microport writes, pin sampling, commits
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = sync_pin;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;
        for (int p = 0; p < NP; p++) begin
            if (st_ff.sync2[p] == st_ff.sync3[p]) begin
                nxt_st.agreed[p] = st_ff.sync2[p];
            end
        end
        nxt_st.soft_start = '0;
        nxt_st.soft_hop   = '0;
        nxt_st.rdy        = !ext_wr;
        if (ext_wr) begin
            case (ext_addr)
                cshs_pkg::EXT_SLEEP: begin
                    nxt_st.sleep = ext_wdata[NC-1:0];
                end
                cshs_pkg::EXT_PIN_CTRL: begin
                    nxt_st.pin_en    = ext_wdata[cshs_pkg::PIN_EN_LSB +: NP];
                    nxt_st.start_pin = ext_wdata[cshs_pkg::START_PIN_BIT];
                    nxt_st.hop_pin   = ext_wdata[cshs_pkg::HOP_PIN_BIT];
                end
                cshs_pkg::EXT_SOFT_SYNC: begin
                    nxt_st.soft_start = ext_wdata[cshs_pkg::SOFT_CH_LSB +: NC] &
                                        {NC{ext_wdata[cshs_pkg::SOFT_START_BIT]}};
                    nxt_st.soft_hop   = ext_wdata[cshs_pkg::SOFT_CH_LSB +: NC] &
                                        {NC{ext_wdata[cshs_pkg::SOFT_HOP_BIT]}};
                end
                default: begin
                end
            endcase
        end
        if (ext_rd) begin
            case (ext_addr)
                cshs_pkg::EXT_SLEEP:    nxt_st.ext_rdata = 8'(st_ff.sleep);
                cshs_pkg::EXT_PIN_CTRL: nxt_st.ext_rdata = {2'h0, st_ff.hop_pin,
                                                            st_ff.start_pin, st_ff.pin_en};
                default:                nxt_st.ext_rdata = 8'h00;
            endcase
        end
        if (creg_wr) begin
            case (creg_addr)
                cshs_pkg::CREG_START_DLY: nxt_st.start_dly[creg_ch] = creg_wdata[CW-1:0];
                cshs_pkg::CREG_TUNE_DLY:  nxt_st.tune_dly[creg_ch]  = creg_wdata[CW-1:0];
                cshs_pkg::CREG_FREQ: begin
                    nxt_st.shadow[creg_ch] = creg_wdata;
                    if (st_ff.tune_dly[creg_ch] == '0) begin
                        nxt_st.tuning[creg_ch] = creg_wdata;
                    end
                end
                cshs_pkg::CREG_PIN_SEL:   nxt_st.pin_sel[creg_ch] = creg_wdata[1:0];
                default: begin
                end
            endcase
        end
        if (creg_rd) begin
            case (creg_addr)
                cshs_pkg::CREG_START_DLY: nxt_st.creg_rdata = FW'(st_ff.start_dly[creg_ch]);
                cshs_pkg::CREG_TUNE_DLY:  nxt_st.creg_rdata = FW'(st_ff.tune_dly[creg_ch]);
                cshs_pkg::CREG_FREQ:      nxt_st.creg_rdata = st_ff.shadow[creg_ch];
                cshs_pkg::CREG_PIN_SEL:   nxt_st.creg_rdata = FW'(st_ff.pin_sel[creg_ch]);
                default:                  nxt_st.creg_rdata = '0;
            endcase
        end
        // Commits override a host write in the same cycle
        for (int c = 0; c < NC; c++) begin
            if (start_fire[c]) begin
                nxt_st.sleep[c] = 1'b0;
            end
            if (hop_fire[c]) begin
                nxt_st.tuning[c] = st_ff.shadow[c];
            end
        end
    end

    // State register; reset sleeps every channel
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff            <= '0;
            st_ff.sleep      <= cshs_pkg::SLEEP_RST;
            st_ff.start_dly  <= {NC{cshs_pkg::START_DLY_RST}};
            st_ff.tune_dly   <= {NC{cshs_pkg::TUNE_DLY_RST}};
            st_ff.rdy        <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state flops
    assign chan_sleep  = st_ff.sleep;
    assign tuning_word = st_ff.tuning;
    assign rdy         = st_ff.rdy;
    assign ext_rdata   = st_ff.ext_rdata;
    assign creg_rdata  = st_ff.creg_rdata;

    chk_reset_sleep: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> chan_sleep == cshs_pkg::SLEEP_RST)
        else $error("channels not asleep after reset");
    chk_start_wake: assert property (@(posedge clk_sys) disable iff (rst)
        start_fire[0] |=> !chan_sleep[0])
        else $error("start commit did not clear sleep");
    chk_hop_commit: assert property (@(posedge clk_sys) disable iff (rst)
        hop_fire[0] |=> tuning_word[0] == $past(st_ff.shadow[0]))
        else $error("hop did not load staged frequency");
    chk_shadow_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !hop_fire[0] && !(creg_wr && creg_ch == 2'h0) |=> $stable(tuning_word[0]))
        else $error("running frequency changed without commit");
    chk_direct_freq: assert property (@(posedge clk_sys) disable iff (rst)
        creg_wr && creg_ch == 2'h0 && creg_addr == cshs_pkg::CREG_FREQ &&
        st_ff.tune_dly[0] == '0 && !hop_fire[0] |=> tuning_word[0] == $past(creg_wdata))
        else $error("zero tuning count did not apply frequency at once");
    chk_soft_start_lat: assert property (@(posedge clk_sys) disable iff (rst)
        ext_wr && ext_addr == cshs_pkg::EXT_SOFT_SYNC && ext_wdata[0] &&
        ext_wdata[cshs_pkg::SOFT_START_BIT] &&
        st_ff.start_dly[0] == 16'h0005 |-> ##12 start_fire[0])
        else $error("soft start latency wrong");
    cov_soft_start: cover property (@(posedge clk_sys) disable iff (rst) start_fire[0]);
    cov_pin_rise: cover property (@(posedge clk_sys) disable iff (rst)
        st_ff.start_pin && pin_rise[0]);
    cov_hop: cover property (@(posedge clk_sys) disable iff (rst) hop_fire[2]);
endmodule
`default_nettype wire

/* cshs_sync_src.sv */
`timescale 1ns/100ps
`default_nettype none
// Sync strobe source standing in for the external timing master
module cshs_sync_src #(
    parameter int HOLD = 4
) (
    input  wire logic                          clk_sys,
    output var  logic [cshs_pkg::NUM_PIN-1:0]  sync_pin
);
    int unsigned age;

    // Idle low until a strobe is requested
    initial begin
        sync_pin = '0;
        age = 0;
    end

    // Strobe stays high HOLD cycles so the device samples it, then drops
    always @(posedge clk_sys) begin
        if (sync_pin !== '0) begin
            age <= (age == HOLD - 1) ? 0 : age + 1;
            if (age == HOLD - 1) begin
                sync_pin <= '0;
            end
        end
    end

    // Raise one strobe; called just after a rising edge
    task automatic raise(input int idx);
        sync_pin[idx] <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* test_cshs_top.sv */
`timescale 1ns/100ps
`default_nettype none
module test_cshs_top;
    logic                                           clk_sys;
    logic                                           rst;
    logic [2:0]                                     ext_addr;
    logic                                           ext_wr;
    logic                                           ext_rd;
    logic [7:0]                                     ext_wdata;
    logic [7:0]                                     ext_rdata;
    logic                                           rdy;
    logic [1:0]                                     creg_ch;
    logic [7:0]                                     creg_addr;
    logic                                           creg_wr;
    logic                                           creg_rd;
    logic [31:0]                                    creg_wdata;
    logic [31:0]                                    creg_rdata;
    logic [3:0]                                     sync_pin;
    logic [3:0]                                     chan_sleep;
    logic [cshs_pkg::NUM_CH-1:0][cshs_pkg::FREQ_W-1:0] tuning_word;
    int                                             miscompares = 0;
    int                                             num_checks = 0;

    cshs_top i_cshs_top (
        .clk_sys, .rst, .ext_addr, .ext_wr, .ext_rd, .ext_wdata, .ext_rdata, .rdy,
        .creg_ch, .creg_addr, .creg_wr, .creg_rd, .creg_wdata, .creg_rdata,
        .sync_pin, .chan_sleep, .tuning_word
    );

    cshs_sync_src i_cshs_sync_src (
        .clk_sys,
        .sync_pin
    );

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One comparison
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // Microport write, taken at the second edge
    task automatic ext_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        ext_addr <= a;
        ext_wdata <= d;
        ext_wr <= 1'b1;
        @(posedge clk_sys);
        ext_wr <= 1'b0;
    endtask

    // Microport read and compare
    task automatic ext_read(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        ext_addr <= a;
        ext_rd <= 1'b1;
        @(posedge clk_sys);
        ext_rd <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(ext_rdata === exp, "ext read");
    endtask

    // Channel register write
    task automatic creg_write(input logic [1:0] ch, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        creg_ch <= ch;
        creg_addr <= a;
        creg_wdata <= d;
        creg_wr <= 1'b1;
        @(posedge clk_sys);
        creg_wr <= 1'b0;
    endtask

    // Channel register read and compare
    task automatic creg_read(input logic [1:0] ch, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        creg_ch <= ch;
        creg_addr <= a;
        creg_rd <= 1'b1;
        @(posedge clk_sys);
        creg_rd <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(creg_rdata === exp, "channel read");
    endtask

    // Bounded wait for ready to return high after a write
    task automatic wait_rdy();
        int n;
        #1;
        chk(rdy === 1'b0, "ready not low after write");
        for (n = 0; n < 4 && rdy !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (rdy !== 1'b1) begin
            chk(1'b0, "ready timeout");
            end_of_test();
        end
    endtask

    // Commit must land exactly at the given edge after the reference
    task automatic wait_commit(input int edges, input int ch, input logic hop,
                               input logic [31:0] fw);
        logic done;
        for (int i = 1; i <= edges; i++) begin
            @(posedge clk_sys);
            #1;
            done = hop ? (tuning_word[ch] === fw) : (chan_sleep[ch] === 1'b0);
            chk(done === (i == edges), "commit timing");
        end
    endtask

    // Hold reset four cycles and check the sleeping state
    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(chan_sleep === 4'hF && tuning_word === '0 && rdy === 1'b1, "reset state");
        @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {ext_addr, ext_wr, ext_rd, ext_wdata} = '0;
        {creg_ch, creg_addr, creg_wr, creg_rd, creg_wdata} = '0;
        do_reset();
        creg_read(2'h0, cshs_pkg::CREG_START_DLY, 32'h0000_0001);
        creg_read(2'h0, cshs_pkg::CREG_TUNE_DLY, 32'h0000_0000);
        ext_read(cshs_pkg::EXT_SLEEP, 8'h0F);
        $display("test reset done");
        // Start without sync, then back to sleep
        creg_write(2'h1, cshs_pkg::CREG_START_DLY, 32'h0000_0001);
        ext_write(cshs_pkg::EXT_SLEEP, 8'h0D);
        @(posedge clk_sys);
        #1;
        chk(chan_sleep === 4'hD, "unsynced start");
        ext_write(cshs_pkg::EXT_SLEEP, 8'h0F);
        @(posedge clk_sys);
        #1;
        chk(chan_sleep === 4'hF, "sleep write");
        $display("test unsynced done");
        // Soft start of channels 0 and 2 after five counts
        creg_write(2'h0, cshs_pkg::CREG_START_DLY, 32'h0000_0005);
        creg_write(2'h2, cshs_pkg::CREG_START_DLY, 32'h0000_0005);
        creg_read(2'h0, cshs_pkg::CREG_START_DLY, 32'h0000_0005);
        ext_write(cshs_pkg::EXT_SOFT_SYNC, 8'h15);
        wait_rdy();
        wait_commit(5 + 6, 0, 1'b0, '0);
        chk(chan_sleep === 4'hA, "soft start mask");
        ext_write(cshs_pkg::EXT_SLEEP, 8'h0F);
        repeat (20) @(posedge clk_sys);
        #1;
        chk(chan_sleep === 4'hF, "counter retriggered");
        $display("test soft start done");
        // Soft hop of channel 0 after four counts
        creg_write(2'h0, cshs_pkg::CREG_TUNE_DLY, 32'h0000_0004);
        creg_write(2'h0, cshs_pkg::CREG_FREQ, 32'h1234_5678);
        #1;
        chk(tuning_word[0] === 32'h0000_0000, "staged frequency leaked");
        ext_write(cshs_pkg::EXT_SOFT_SYNC, 8'h21);
        wait_rdy();
        wait_commit(4 + 7, 0, 1'b1, 32'h1234_5678);
        $display("test soft hop done");
        // Zero tuning count applies the frequency at once
        creg_write(2'h3, cshs_pkg::CREG_FREQ, 32'hA5A5_5A5A);
        #1;
        chk(tuning_word[3] === 32'hA5A5_5A5A, "immediate frequency");
        $display("test direct frequency done");
        // Pin start of channels 1 and 3 sharing pin C
        creg_write(2'h1, cshs_pkg::CREG_PIN_SEL, 32'h0000_0002);
        creg_write(2'h3, cshs_pkg::CREG_PIN_SEL, 32'h0000_0002);
        creg_write(2'h1, cshs_pkg::CREG_START_DLY, 32'h0000_0003);
        creg_write(2'h3, cshs_pkg::CREG_START_DLY, 32'h0000_0003);
        ext_write(cshs_pkg::EXT_PIN_CTRL, 8'h14);
        @(posedge clk_sys);
        i_cshs_sync_src.raise(0);
        repeat (12) @(posedge clk_sys);
        #1;
        chk(chan_sleep === 4'hF, "disabled pin acted");
        @(posedge clk_sys);
        i_cshs_sync_src.raise(2);
        wait_commit(3 + 4, 3, 1'b0, '0);
        chk(chan_sleep === 4'h5, "shared pin start");
        $display("test pin start done");
        // Pin hop of channel 2 on pin B
        creg_write(2'h2, cshs_pkg::CREG_PIN_SEL, 32'h0000_0001);
        creg_write(2'h2, cshs_pkg::CREG_TUNE_DLY, 32'h0000_0002);
        creg_write(2'h2, cshs_pkg::CREG_FREQ, 32'hCAFE_0001);
        ext_write(cshs_pkg::EXT_PIN_CTRL, 8'h22);
        @(posedge clk_sys);
        i_cshs_sync_src.raise(1);
        wait_commit(2 + 6, 2, 1'b1, 32'hCAFE_0001);
        $display("test pin hop done");
        // Unmapped places are ignored and read zero
        ext_write(3'h6, 8'h00);
        ext_read(cshs_pkg::EXT_SLEEP, 8'h05);
        ext_read(cshs_pkg::EXT_SOFT_SYNC, 8'h00);
        creg_read(2'h0, 8'h90, 32'h0000_0000);
        ext_read(cshs_pkg::EXT_PIN_CTRL, 8'h22);
        creg_read(2'h2, cshs_pkg::CREG_FREQ, 32'hCAFE_0001);
        creg_read(2'h2, cshs_pkg::CREG_PIN_SEL, 32'h0000_0001);
        $display("test unmapped done");
        do_reset();
        creg_read(2'h0, cshs_pkg::CREG_START_DLY, 32'h0000_0001);
        ext_read(cshs_pkg::EXT_PIN_CTRL, 8'h00);
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
